// *** logic/simd_pkg.sv ***
// shared constants and types for the packed integer move/abs datapath
package simd_pkg;

    // ------------------------------------------------------------
    // operand geometry
    // ------------------------------------------------------------
    localparam int WIDE_W = 128;
    localparam int NARROW_W = 64;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    localparam int SHUF_SEL_W = 4;
    localparam int SHUF_ZERO_BIT = 7;

    // ------------------------------------------------------------
    // floating point formats
    // ------------------------------------------------------------
    localparam int SP_EXP_W = 8;
    localparam int SP_MAN_W = 23;
    localparam int DP_EXP_W = 11;
    localparam int DP_MAN_W = 52;
    localparam logic [31:0] INT_INDEFINITE = 32'h8000_0000;

    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam int RESULT_LATENCY = 1;
    localparam logic [127:0] RESULT_RESET = 128'h0;

    // ------------------------------------------------------------
    // operation and lane codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LANE_BYTE = 2'h0,
        LANE_WORD = 2'h1,
        LANE_DWORD = 2'h2
    } lane_t;

    typedef enum logic [4:0] {
        OP_ILV_LO = 5'h00,
        OP_ILV_HI = 5'h01,
        OP_NARROW_TO_WIDE = 5'h02,
        OP_WIDE_TO_NARROW = 5'h03,
        OP_CVT_S2I = 5'h04,
        OP_CVT_I2S = 5'h05,
        OP_CVT_D2I = 5'h06,
        OP_CVT_I2D = 5'h07,
        OP_XOR = 5'h08,
        OP_CMPEQ = 5'h09,
        OP_SUB = 5'h0a,
        OP_USAT_SUB = 5'h0b,
        OP_SHL = 5'h0c,
        OP_SHR = 5'h0d,
        OP_ABS = 5'h0e,
        OP_MAX_S = 5'h0f,
        OP_SHUFFLE = 5'h10
    } op_t;

endpackage

// *** logic/lane_arith.sv ***
// one packed lane: subtract, saturating subtract, max, abs, equality
`timescale 1ns/100ps
module lane_arith #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    output logic [W-1:0] diff_o,
    output logic [W-1:0] usat_o,
    output logic [W-1:0] max_o,
    output logic [W-1:0] abs_o,
    output logic [W-1:0] eq_o
);
    logic [W-1:0] neg_b;

    // wrapping difference, no borrow leaves the lane
    assign diff_o = a_i - b_i;
    // unsigned compare, negative result clamps to zero
    assign usat_o = (a_i > b_i) ? (a_i - b_i) : '0;
    assign max_o = ($signed(a_i) > $signed(b_i)) ? a_i : b_i;
    // abs as max(-b, b): the most negative value maps onto itself
    assign neg_b = '0 - b_i;
    assign abs_o = ($signed(neg_b) > $signed(b_i)) ? neg_b : b_i;
    assign eq_o = (a_i == b_i) ? '1 : '0;
endmodule // lane_arith

// *** logic/fp_int_conv.sv ***
// one float lane to/from a 32-bit signed integer, round toward zero
`timescale 1ns/100ps
module fp_int_conv #(
    parameter int EW = 8,
    parameter int MW = 23
) (
    input wire logic [EW+MW:0] fp_i,
    input wire logic [31:0] int_i,
    output logic [31:0] int_o,
    output logic [EW+MW:0] fp_o
);
    import simd_pkg::*;

    localparam int BIAS = (1 << (EW - 1)) - 1;

    int e;
    int p;
    logic [63:0] mag;
    logic [31:0] imag;
    logic [63:0] norm;

    // float to integer: out of range gives the indefinite pattern
    always_comb begin
        e = int'(fp_i[EW+MW-1:MW]) - BIAS;
        mag = 64'h0;
        int_o = 32'h0;
        if (e >= 31) begin
            int_o = INT_INDEFINITE;
        end else if (e >= 0) begin
            mag = 64'({1'b1, fp_i[MW-1:0]});
            if (e >= MW) begin
                mag = mag << (e - MW);
            end else begin
                mag = mag >> (MW - e);
            end
            int_o = fp_i[EW+MW] ? 32'(64'h0 - mag) : mag[31:0];
        end
    end

    // integer to float: single drops low bits, double is exact
    always_comb begin
        imag = int_i[31] ? (32'h0 - int_i) : int_i;
        p = 0;
        for (int i = 0; i < 32; i++) begin
            if (imag[i]) begin
                p = i;
            end
        end
        norm = 64'({imag, 32'h0}) << (31 - p);
        fp_o = '0;
        if (imag != 32'h0) begin
            fp_o[EW+MW] = int_i[31];
            fp_o[EW+MW-1:MW] = EW'(BIAS + p);
            fp_o[MW-1:0] = norm[62 -: MW];
        end
    end
endmodule // fp_int_conv

// *** logic/simd_move_abs_unit.sv ***
// packed integer move, interleave, convert, abs and shuffle datapath
//
// Function
// RL1 - low/high interleave joins matching halves of destination and source
// RL2 - unselected halves of both operands never reach the result
// RL3 - narrow to wide move fills low half, zeroes upper 64 bits
// RL4 - wide to narrow move copies only the source low 64 bits
// RL5 - four single lanes convert to four dwords, and back
// RL6 - double lanes convert to dwords and back
// RL7 - no operation loads an immediate constant into a register
// RL8 - xor of a register with itself gives all zeros
// RL9 - equality compare of a register with itself gives all ones
// RL10 - zero minus all ones gives one in every lane
// RL11 - packed shifts exist for words and dwords only, never bytes
// RL12 - unsigned saturating subtract clamps negative lanes to zero
// RL13 - unsigned saturating subtract for bytes and words, not dwords
// RL14 - packed abs on 128 bits at byte, word, dword lanes
// RL15 - abs of the most negative lane value returns it unchanged
// RL16 - byte shuffle rearranges bytes anywhere within sixteen bytes
// RL17 - every lane computed alone, nothing crosses lane boundaries
`timescale 1ns/100ps
module simd_move_abs_unit (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire simd_pkg::op_t opcode_i,
    input wire simd_pkg::lane_t lane_i,
    input wire logic [7:0] shift_count_i,
    input wire logic [127:0] dst_i,
    input wire logic [127:0] src_i,
    output logic [127:0] result_o,
    output logic result_valid_o,
    output logic narrow_dest_o,
    output logic illegal_o
);
    import simd_pkg::*;

    // ------------------------------------------------------------
    // per lane arithmetic
    // ------------------------------------------------------------
    logic [127:0] diff_b, diff_w, diff_d;
    logic [127:0] usat_b, usat_w, usat_d;
    logic [127:0] max_b, max_w, max_d;
    logic [127:0] abs_b, abs_w, abs_d;
    logic [127:0] eq_b, eq_w, eq_d;

    // RL17 independent lane slices
    for (genvar g = 0; g < WIDE_W / BYTE_W; g++) begin : g_byte
        lane_arith #(.W(BYTE_W)) u_lane (
            .a_i(dst_i[g*BYTE_W +: BYTE_W]),
            .b_i(src_i[g*BYTE_W +: BYTE_W]),
            .diff_o(diff_b[g*BYTE_W +: BYTE_W]),
            .usat_o(usat_b[g*BYTE_W +: BYTE_W]),
            .max_o(max_b[g*BYTE_W +: BYTE_W]),
            .abs_o(abs_b[g*BYTE_W +: BYTE_W]),
            .eq_o(eq_b[g*BYTE_W +: BYTE_W])
        );
    end
    for (genvar g = 0; g < WIDE_W / WORD_W; g++) begin : g_word
        lane_arith #(.W(WORD_W)) u_lane (
            .a_i(dst_i[g*WORD_W +: WORD_W]),
            .b_i(src_i[g*WORD_W +: WORD_W]),
            .diff_o(diff_w[g*WORD_W +: WORD_W]),
            .usat_o(usat_w[g*WORD_W +: WORD_W]),
            .max_o(max_w[g*WORD_W +: WORD_W]),
            .abs_o(abs_w[g*WORD_W +: WORD_W]),
            .eq_o(eq_w[g*WORD_W +: WORD_W])
        );
    end
    for (genvar g = 0; g < WIDE_W / DWORD_W; g++) begin : g_dword
        lane_arith #(.W(DWORD_W)) u_lane (
            .a_i(dst_i[g*DWORD_W +: DWORD_W]),
            .b_i(src_i[g*DWORD_W +: DWORD_W]),
            .diff_o(diff_d[g*DWORD_W +: DWORD_W]),
            .usat_o(usat_d[g*DWORD_W +: DWORD_W]),
            .max_o(max_d[g*DWORD_W +: DWORD_W]),
            .abs_o(abs_d[g*DWORD_W +: DWORD_W]),
            .eq_o(eq_d[g*DWORD_W +: DWORD_W])
        );
    end

    // ------------------------------------------------------------
    // conversion lanes
    // ------------------------------------------------------------
    logic [127:0] s2i, i2s, i2d;
    logic [63:0] d2i;

    // RL5 four single lanes
    for (genvar g = 0; g < 4; g++) begin : g_single
        fp_int_conv #(.EW(SP_EXP_W), .MW(SP_MAN_W)) u_conv (
            .fp_i(src_i[g*32 +: 32]),
            .int_i(src_i[g*32 +: 32]),
            .int_o(s2i[g*32 +: 32]),
            .fp_o(i2s[g*32 +: 32])
        );
    end
    // RL6 two double lanes
    for (genvar g = 0; g < 2; g++) begin : g_double
        fp_int_conv #(.EW(DP_EXP_W), .MW(DP_MAN_W)) u_conv (
            .fp_i(src_i[g*64 +: 64]),
            .int_i(src_i[g*32 +: 32]),
            .int_o(d2i[g*32 +: 32]),
            .fp_o(i2d[g*64 +: 64])
        );
    end

    // ------------------------------------------------------------
    // shifts and shuffle
    // ------------------------------------------------------------
    logic [127:0] shl_w, shr_w, shl_d, shr_d;
    logic [127:0] shuf;

    // RL11 word and dword shifts only
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            shl_w[i*16 +: 16] = (shift_count_i > 8'h0f) ? 16'h0
                : dst_i[i*16 +: 16] << shift_count_i[3:0];
            shr_w[i*16 +: 16] = (shift_count_i > 8'h0f) ? 16'h0
                : dst_i[i*16 +: 16] >> shift_count_i[3:0];
        end
        for (int i = 0; i < 4; i++) begin
            shl_d[i*32 +: 32] = (shift_count_i > 8'h1f) ? 32'h0
                : dst_i[i*32 +: 32] << shift_count_i[4:0];
            shr_d[i*32 +: 32] = (shift_count_i > 8'h1f) ? 32'h0
                : dst_i[i*32 +: 32] >> shift_count_i[4:0];
        end
    end

    // RL16 any byte to any byte position
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (src_i[i*8 + SHUF_ZERO_BIT]) begin
                shuf[i*8 +: 8] = 8'h0;
            end else begin
                shuf[i*8 +: 8] =
                    dst_i[src_i[i*8 +: SHUF_SEL_W]*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------
    logic [127:0] next_result;
    logic next_illegal;
    logic next_narrow;
    logic lane_ok;

    assign lane_ok = (lane_i == LANE_BYTE) || (lane_i == LANE_WORD)
        || (lane_i == LANE_DWORD);

    always_comb begin
        next_result = 128'h0;
        next_illegal = 1'b0;
        next_narrow = 1'b0;
        unique case (opcode_i)
            // RL1 RL2 low halves joined
            OP_ILV_LO: next_result = {src_i[63:0], dst_i[63:0]};
            // RL1 RL2 high halves joined
            OP_ILV_HI: next_result = {src_i[127:64], dst_i[127:64]};
            // RL3 upper half cleared
            OP_NARROW_TO_WIDE: next_result = {64'h0, src_i[63:0]};
            // RL4 low half only
            OP_WIDE_TO_NARROW: begin
                next_result = {64'h0, src_i[63:0]};
                next_narrow = 1'b1;
            end
            // RL5 single to dword and back
            OP_CVT_S2I: next_result = s2i;
            OP_CVT_I2S: next_result = i2s;
            // RL6 double to dword and back
            OP_CVT_D2I: next_result = {64'h0, d2i};
            OP_CVT_I2D: next_result = i2d;
            // RL8 self xor clears
            OP_XOR: next_result = dst_i ^ src_i;
            // RL9 self compare sets all
            OP_CMPEQ: begin
                next_illegal = !lane_ok;
                next_result = (lane_i == LANE_BYTE) ? eq_b
                    : (lane_i == LANE_WORD) ? eq_w : eq_d;
            end
            // RL10 lane sized wrapping subtract
            OP_SUB: begin
                next_illegal = !lane_ok;
                next_result = (lane_i == LANE_BYTE) ? diff_b
                    : (lane_i == LANE_WORD) ? diff_w : diff_d;
            end
            // RL12 RL13 clamp, bytes and words only
            OP_USAT_SUB: begin
                next_illegal = (lane_i != LANE_BYTE)
                    && (lane_i != LANE_WORD);
                next_result = (lane_i == LANE_BYTE) ? usat_b : usat_w;
            end
            // RL11 byte shifts refused
            OP_SHL: begin
                next_illegal = (lane_i != LANE_WORD)
                    && (lane_i != LANE_DWORD);
                next_result = (lane_i == LANE_WORD) ? shl_w : shl_d;
            end
            OP_SHR: begin
                next_illegal = (lane_i != LANE_WORD)
                    && (lane_i != LANE_DWORD);
                next_result = (lane_i == LANE_WORD) ? shr_w : shr_d;
            end
            // RL14 RL15 abs at three lane sizes
            OP_ABS: begin
                next_illegal = !lane_ok;
                next_result = (lane_i == LANE_BYTE) ? abs_b
                    : (lane_i == LANE_WORD) ? abs_w : abs_d;
            end
            OP_MAX_S: begin
                next_illegal = !lane_ok;
                next_result = (lane_i == LANE_BYTE) ? max_b
                    : (lane_i == LANE_WORD) ? max_w : max_d;
            end
            // RL16 byte shuffle
            OP_SHUFFLE: next_result = shuf;
            // RL7 no immediate load exists; unknown codes refused
            default: next_illegal = 1'b1;
        endcase
        if (next_illegal) begin
            next_result = 128'h0;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // result holds until the next accepted operation
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_o <= RESULT_RESET;
            narrow_dest_o <= 1'b0;
            illegal_o <= 1'b0;
        end else if (op_valid_i) begin
            result_o <= next_result;
            narrow_dest_o <= next_narrow;
            illegal_o <= next_illegal;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= op_valid_i;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    function automatic logic is_op(op_t o);
        return op_valid_i && (opcode_i == o);
    endfunction

    ilv_low_a: // RL1
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_ILV_LO) |=> result_valid_o
            && result_o == {$past(src_i[63:0]), $past(dst_i[63:0])})
    else $error("low interleave result wrong");

    ilv_high_a: // RL2
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_ILV_HI) |=> !illegal_o
            && result_o[63:0] == $past(dst_i[127:64])
            && result_o[127:64] == $past(src_i[127:64]))
    else $error("high interleave used low halves");

    narrow_wide_a: // RL3
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_NARROW_TO_WIDE) |=> result_o[127:64] == 64'h0
            && result_o[63:0] == $past(src_i[63:0]) && !narrow_dest_o)
    else $error("narrow to wide move wrong");

    wide_narrow_a: // RL4
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_WIDE_TO_NARROW) |=> narrow_dest_o
            && result_o == {64'h0, $past(src_i[63:0])})
    else $error("wide to narrow move wrong");

    xor_zero_a: // RL8
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_XOR) && dst_i == src_i |=> result_o == 128'h0)
    else $error("self xor not zero");

    cmpeq_ones_a: // RL9
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_CMPEQ) && lane_ok && dst_i == src_i
            |=> result_o == {128{1'b1}})
    else $error("self compare not all ones");

    sub_one_a: // RL10
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_SUB) && lane_i == LANE_WORD && dst_i == 128'h0
            && src_i == {128{1'b1}}
            |=> result_o == {8{16'h0001}})
    else $error("zero minus ones not one per word");

    byte_shift_a: // RL11
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (is_op(OP_SHL) || is_op(OP_SHR)) && lane_i == LANE_BYTE
            |=> illegal_o && result_o == 128'h0)
    else $error("byte shift accepted");

    usat_clamp_a: // RL12
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_USAT_SUB) && lane_i == LANE_BYTE
            && src_i[7:0] > dst_i[7:0] |=> result_o[7:0] == 8'h0)
    else $error("saturating subtract did not clamp");

    usat_dword_a: // RL13
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_USAT_SUB) && lane_i == LANE_DWORD |=> illegal_o)
    else $error("dword saturating subtract accepted");

    abs_min_a: // RL15
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_ABS) && lane_i == LANE_WORD && src_i[63:48] == 16'h8000
            |=> result_o[63:48] == 16'h8000)
    else $error("abs of most negative changed");

    lane_borrow_a: // RL17
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_SUB) && lane_i == LANE_BYTE && dst_i[7:0] == 8'h00
            && src_i[7:0] == 8'h01 && dst_i[15:8] == src_i[15:8]
            |=> result_o[15:0] == 16'h00ff)
    else $error("borrow crossed a byte lane");

    shuf_zero_a: // RL16
    assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        is_op(OP_SHUFFLE) && src_i[SHUF_ZERO_BIT]
            |=> result_o[7:0] == 8'h0 && !illegal_o)
    else $error("shuffle zero select ignored");

    shuffle_seen_c: cover property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) is_op(OP_SHUFFLE) ##1 result_valid_o);
    convert_seen_c: cover property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) is_op(OP_CVT_S2I) ##1 is_op(OP_CVT_I2S));
    refuse_seen_c: cover property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) is_op(OP_USAT_SUB) ##1 illegal_o);
    abs_seen_c: cover property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) is_op(OP_ABS) && lane_i == LANE_BYTE);

endmodule // simd_move_abs_unit

// *** verification/issue_model.sv ***
// issue-side model that hands operations to the datapath
`timescale 1ns/100ps
module issue_model (
    input wire logic clk_i,
    output logic op_valid_o,
    output simd_pkg::op_t opcode_o,
    output simd_pkg::lane_t lane_o,
    output logic [7:0] count_o,
    output logic [127:0] dst_o,
    output logic [127:0] src_o
);
    import simd_pkg::*;
    // ------------------------------------------------------------
    // issue and release
    // ------------------------------------------------------------
    initial begin
        op_valid_o = 1'h0;
        opcode_o = OP_XOR;
        lane_o = LANE_BYTE;
        count_o = 8'h00;
        dst_o = 128'h0;
        src_o = 128'h0;
    end
    // called at a falling edge; request stays up until the next issue or idle call
    task automatic issue(input op_t op, input lane_t ln,
        input logic [7:0] c, input logic [127:0] d, input logic [127:0] s);
        op_valid_o = 1'h1;
        opcode_o = op;
        lane_o = ln;
        count_o = c;
        dst_o = d;
        src_o = s;
        @(negedge clk_i);
    endtask
    // released operands flip so stale data cannot pass for a live request
    task automatic idle();
        op_valid_o = 1'h0;
        dst_o = ~dst_o;
        src_o = ~src_o;
        @(negedge clk_i);
    endtask
endmodule // issue_model

// *** verification/tb.sv ***
// self-checking bench for the packed move/abs datapath
`timescale 1ns/100ps
module tb;
    import simd_pkg::*;
    // ------------------------------------------------------------
    // set-up
    // ------------------------------------------------------------
    typedef struct {
        op_t op;
        lane_t ln;
        logic [7:0] c;
        logic [127:0] d;
        logic [127:0] s;
        logic [127:0] e;
        logic ill;
    } row_t;
    localparam logic [127:0] D = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    localparam logic [127:0] S = 128'h9999_aaaa_bbbb_cccc_dddd_eeee_ffff_0000;
    localparam logic [63:0] P = 64'h8000_fffe_0005_ff80;
    localparam int LIMIT = 1000;
    logic sys_clk_i;
    logic rst_n_i;
    logic op_valid;
    op_t opcode;
    lane_t lane;
    logic [7:0] count;
    logic [127:0] dst;
    logic [127:0] src;
    logic [127:0] result_o;
    logic result_valid_o;
    logic narrow_dest_o;
    logic illegal_o;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    row_t rows[$];

    issue_model um (.clk_i(sys_clk_i), .op_valid_o(op_valid),
        .opcode_o(opcode), .lane_o(lane), .count_o(count), .dst_o(dst),
        .src_o(src));
    simd_move_abs_unit dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .op_valid_i(op_valid), .opcode_i(opcode), .lane_i(lane),
        .shift_count_i(count), .dst_i(dst), .src_i(src),
        .result_o(result_o), .result_valid_o(result_valid_o),
        .narrow_dest_o(narrow_dest_o), .illegal_o(illegal_o));

    initial sys_clk_i = 1'h0;
    always #20 sys_clk_i = ~sys_clk_i;
    // a hang is cut short well after the roughly sixty cycles needed
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_res(input logic [127:0] got, input logic [127:0] exp,
        input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask
    function automatic void row(input op_t op, input lane_t ln,
        input logic [7:0] c, input logic [127:0] d, input logic [127:0] s,
        input logic [127:0] e, input logic ill);
        rows.push_back('{op, ln, c, d, s, e, ill});
    endfunction
    task automatic check(input row_t r);
        chk_res(result_o, r.e, "result");
        chk_flag(illegal_o, r.ill, "refusal flag");
        chk_flag(result_valid_o, 1'h1, "valid pulse");
        chk_flag(narrow_dest_o, 1'h0, "narrow flag");
    endtask
    task automatic chk_quiet();
        chk_res(result_o, 128'h0, "result in reset");
        chk_flag(result_valid_o, 1'h0, "valid in reset");
        chk_flag(illegal_o, 1'h0, "refusal in reset");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n_i = 1'h0;
        row(OP_ILV_LO, LANE_BYTE, 8'h00, D, S, {S[63:0], D[63:0]}, 1'h0);
        row(OP_ILV_LO, LANE_BYTE, 8'h00, {~D[127:64], D[63:0]},
            {64'h0, S[63:0]}, {S[63:0], D[63:0]}, 1'h0);
        row(OP_ILV_HI, LANE_BYTE, 8'h00, D, S,
            {S[127:64], D[127:64]}, 1'h0);
        row(OP_ILV_HI, LANE_BYTE, 8'h00, {D[127:64], ~D[63:0]},
            {S[127:64], 64'h0}, {S[127:64], D[127:64]}, 1'h0);
        row(OP_NARROW_TO_WIDE, LANE_BYTE, 8'h00, ~D, S,
            {64'h0, S[63:0]}, 1'h0);
        row(OP_XOR, LANE_BYTE, 8'h00, D, D, 128'h0, 1'h0);
        for (int l = 0; l < 3; l++) begin
            row(OP_CMPEQ, lane_t'(l), 8'h00, D, D, ~128'h0, 1'h0);
        end
        row(OP_SUB, LANE_BYTE, 8'h00, 128'h0, ~128'h0, {16{8'h01}}, 1'h0);
        row(OP_SUB, LANE_WORD, 8'h00, 128'h0, ~128'h0, {8{16'h1}}, 1'h0);
        row(OP_SUB, LANE_DWORD, 8'h00, 128'h0, ~128'h0, {4{32'h1}}, 1'h0);
        row(OP_SUB, LANE_BYTE, 8'h00, 128'h0, 128'h1, 128'hff, 1'h0);
        row(OP_USAT_SUB, LANE_BYTE, 8'h00, {8{16'h1020}}, {8{16'h0030}},
            {8{16'h1000}}, 1'h0);
        row(OP_USAT_SUB, LANE_WORD, 8'h00, {8{16'h1020}}, {8{16'h0030}},
            {8{16'h0ff0}}, 1'h0);
        row(OP_USAT_SUB, LANE_DWORD, 8'h00, D, S, 128'h0, 1'h1);
        row(OP_SHL, LANE_WORD, 8'h04, D, S,
            128'h1110_2220_3330_4440_5550_6660_7770_8880, 1'h0);
        row(OP_SHR, LANE_DWORD, 8'h04, D, S,
            128'h0111_1222_0333_3444_0555_5666_0777_7888, 1'h0);
        row(OP_SHL, LANE_BYTE, 8'h01, D, S, 128'h0, 1'h1);
        row(OP_SHR, LANE_BYTE, 8'h01, D, S, 128'h0, 1'h1);
        row(OP_SHR, LANE_WORD, 8'h10, D, S, 128'h0, 1'h0);
        row(OP_ABS, LANE_BYTE, 8'h00, D, {2{P}},
            {2{64'h8000_0102_0005_0180}}, 1'h0);
        row(OP_ABS, LANE_WORD, 8'h00, D, {2{P}},
            {2{64'h8000_0002_0005_0080}}, 1'h0);
        row(OP_ABS, LANE_DWORD, 8'h00, D, {2{P}},
            {2{64'h7fff_0002_0005_ff80}}, 1'h0);
        row(OP_MAX_S, LANE_WORD, 8'h00, D, S,
            128'h1111_2222_3333_4444_5555_6666_7777_0000, 1'h0);
        row(OP_SHUFFLE, LANE_BYTE, 8'h00,
            128'h0f0e0d0c_0b0a0908_07060504_03020100,
            128'h00010203_04050607_08090a0b_0c0d0e80,
            128'h00010203_04050607_08090a0b_0c0d0e00, 1'h0);
        row(OP_CVT_S2I, LANE_DWORD, 8'h00, D,
            128'h42c80000_c0200000_3f800000_00000000,
            128'h00000064_fffffffe_00000001_00000000, 1'h0);
        row(OP_CVT_I2S, LANE_DWORD, 8'h00, D,
            128'h00000064_fffffffe_00000001_00000000,
            128'h42c80000_c0000000_3f800000_00000000, 1'h0);
        row(OP_CVT_D2I, LANE_DWORD, 8'h00, D,
            {64'hc008_0000_0000_0000, 64'h3ff0_0000_0000_0000},
            {64'h0, 64'hffff_fffd_0000_0001}, 1'h0);
        row(OP_CVT_I2D, LANE_DWORD, 8'h00, D,
            {64'h0, 64'hffff_fffd_0000_0001},
            {64'hc008_0000_0000_0000, 64'h3ff0_0000_0000_0000}, 1'h0);
        row(OP_CMPEQ, lane_t'(2'h3), 8'h00, D, D, 128'h0, 1'h1);
        repeat (5) @(negedge sys_clk_i);
        chk_quiet();
        rst_n_i = 1'h1;
        // rows go back to back, first one on the first edge after release
        foreach (rows[i]) begin
            um.issue(rows[i].op, rows[i].ln, rows[i].c, rows[i].d, rows[i].s);
            check(rows[i]);
        end
        um.issue(OP_WIDE_TO_NARROW, LANE_BYTE, 8'h00, D, S);
        chk_res({64'h0, result_o[63:0]}, {64'h0, S[63:0]}, "wide to narrow");
        chk_flag(narrow_dest_o, 1'h1, "narrow flag set");
        um.idle();
        chk_flag(result_valid_o, 1'h0, "valid one cycle");
        chk_flag(narrow_dest_o, 1'h1, "narrow flag holds");
        // every unassigned code, immediate loads included, is refused
        for (int k = 17; k < 32; k++) begin
            um.issue(op_t'(5'(k)), LANE_BYTE, 8'h00, D, S);
            chk_flag(illegal_o, 1'h1, "unknown code refused");
            chk_res(result_o, 128'h0, "unknown code result");
        end
        um.issue(OP_CMPEQ, LANE_WORD, 8'h00, D, D);
        rst_n_i = 1'h0;
        #1;
        chk_quiet();
        um.idle();
        rst_n_i = 1'h1;
        um.idle();
        chk_quiet();
        um.issue(OP_SUB, LANE_BYTE, 8'h00, 128'h0, ~128'h0);
        chk_res(result_o, {16{8'h01}}, "after second reset");
        um.idle();
        tally_and_finish();
    end
endmodule // tb
